/* File: shared/crp_pkg.sv */
// Constants and state types for the conversion readback port.
package crp_pkg;
  localparam int          SYS_CLK_PERIOD_NS      = 100;
  localparam int          MASTER_CLOCK_PERIOD_NS = 100;
  localparam int          PRE_STROBE_PERIODS     = 1;
  localparam int          PRE_STROBE_CYCLES      =
    (PRE_STROBE_PERIODS * MASTER_CLOCK_PERIOD_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
  localparam int          WORD_BITS   = 32;
  localparam int          RES_BITS    = 24;
  localparam int          SUF_BITS    = 8;
  localparam int          CNT_W       = 6;
  localparam int          SYNC_W      = 2;
  localparam logic [5:0]  WORD_LEN    = 6'h20;
  localparam logic [5:0]  CNT_RST     = 6'h00;
  localparam logic [31:0] WORD_RST    = 32'h00000000;
  localparam logic [7:0]  CRC_POLY    = 8'h07;
  localparam logic [7:0]  CRC_INIT    = 8'h00;
  // Status byte layout.
  localparam int          ST_SUMMARY  = 7;
  localparam int          ST_ERR_HI   = 6;
  localparam int          ST_ERR_LO   = 1;
  localparam int          ST_POR      = 0;
  localparam int          ERR_W       = 6;
  localparam logic        SDO_RESET   = 1'b0;
  localparam logic        POR_PINMODE = 1'b1;

  typedef struct packed {
    logic [31:0] pend;
    logic        pend_v;
    logic [31:0] word;
    logic [5:0]  cnt;
    logic        armed;
    logic        sdo;
    logic        sdo_oe;
    logic        strobe;
    logic        sclk_prev;
    logic        flag;
  } crp_state_t;
endpackage

/* File: rtl/crp_sync.sv */
// Two flip-flop synchroniser for pin inputs.
`timescale 1ns/1ps
module crp_sync
  import crp_pkg::*;
(
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  // Pins in, synchronised levels out
  input  wire logic [SYNC_W-1:0] async_in,
  output logic      [SYNC_W-1:0] sync_out
);
  logic [SYNC_W-1:0] meta_ff;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      // Both pins idle high, so a low reset value would fake a select and an edge.
      meta_ff  <= '1;
      sync_out <= '1;
    end else begin
      meta_ff  <= async_in;
      sync_out <= meta_ff;
    end
  end
endmodule

/* File: rtl/crp_readback.sv */
// Conversion readback port: 32-bit result word shifted out on the serial clock.
`timescale 1ns/1ps
// Summary of operation
// - Pin mode forces continuous readback.
// - Shift 24 result bits plus eight suffix.
// - Pin mode suffix is always status.
// - Last bit held until next conversion (addressed mode) or strobe.
// - Output resets on strobe rising edge.
// - MSB on first falling serial clock edge.
// - Pin mode final bit always one.
// - Ready flag on continuous or short readback.
// - Ready flag arms readback only in continuous mode.
// - Addressed mode resets output one cycle early.
// - Summary error is OR of others.
// - Pin mode power-on flag reads one.
module crp_readback
  import crp_pkg::*;
(
  // Clock and reset
  input  wire logic                sys_clk,
  input  wire logic                rst_n,
  // Converter side
  input  wire logic                conv_valid,
  input  wire logic [RES_BITS-1:0] conv_data,
  input  wire logic [ERR_W-1:0]    err_flags,
  input  wire logic                por_flag,
  // Mode straps and controls
  input  wire logic                pin_mode,
  input  wire logic                cont_mode,
  input  wire logic                crc_sel,
  input  wire logic                read_req,
  // Serial pins and sample ready strobe
  input  wire logic                sclk,
  input  wire logic                cs_n,
  output logic                     sdo,
  output logic                     sdo_oe,
  output logic                     sample_ready_strobe
);
  crp_state_t        s_ff;
  crp_state_t        nxt_s;
  logic [SYNC_W-1:0] pins_sync;
  logic              sclk_s;
  logic              cs_n_s;
  logic              cont_eff;
  logic              sclk_fall;
  logic [7:0]        status_b;
  logic [7:0]        suffix;

  crp_sync u_sync (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .async_in ({cs_n, sclk}),
    .sync_out (pins_sync)
  );

  function automatic logic [7:0] crc8(input logic [RES_BITS-1:0] d);
    logic [7:0] c;
    c = CRC_INIT;
    for (int i = RES_BITS - 1; i >= 0; i--) begin
      c = (c[7] ^ d[i]) ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
    end
    return c;
  endfunction

  assign sclk_s    = pins_sync[0];
  assign cs_n_s    = pins_sync[1];
  assign cont_eff  = pin_mode | cont_mode;
  assign sclk_fall = s_ff.sclk_prev & ~sclk_s;

  // The suffix byte is built from the levels present when the conversion arrives.
  always_comb begin
    status_b                     = '0;
    status_b[ST_ERR_HI:ST_ERR_LO] = err_flags;
    status_b[ST_SUMMARY]         = |err_flags;
    status_b[ST_POR]             = pin_mode ? POR_PINMODE : por_flag;
    suffix = (crc_sel && !pin_mode) ? crc8(conv_data) : status_b;
  end

  // A new conversion is parked for one cycle, then copied into the shift word
  // while the strobe pulses and the bit count restarts, even in the middle of a readback.
  always_comb begin
    nxt_s           = s_ff;
    nxt_s.sclk_prev = sclk_s;
    nxt_s.strobe    = 1'b0;
    nxt_s.sdo_oe    = ~cs_n_s;
    if (conv_valid) begin
      nxt_s.pend   = {conv_data, suffix};
      nxt_s.pend_v = 1'b1;
      nxt_s.flag   = cont_eff | (s_ff.cnt != WORD_LEN);
      if (!cont_eff) begin
        nxt_s.sdo   = SDO_RESET;
        nxt_s.armed = 1'b0;
      end
    end else if (s_ff.pend_v) begin
      nxt_s.pend_v = 1'b0;
      nxt_s.strobe = 1'b1;
      nxt_s.word   = s_ff.pend;
      nxt_s.cnt    = CNT_RST;
      nxt_s.sdo    = SDO_RESET;
      nxt_s.armed  = cont_eff & s_ff.flag;
    end else if (cs_n_s) begin
      // Deselecting clears the bit count so a host can regain alignment.
      nxt_s.cnt = CNT_RST;
    end else begin
      if (read_req && !cont_eff) begin
        nxt_s.armed = 1'b1;
        nxt_s.cnt   = CNT_RST;
      end
      if (sclk_fall && s_ff.armed && s_ff.cnt != WORD_LEN) begin
        nxt_s.sdo = s_ff.word[WORD_BITS - 1 - int'(s_ff.cnt)];
        nxt_s.cnt = s_ff.cnt + 6'h01;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s_ff <= '{pend: WORD_RST, pend_v: 1'b0, word: WORD_RST, cnt: CNT_RST,
                armed: 1'b0, sdo: SDO_RESET, sdo_oe: 1'b0, strobe: 1'b0,
                sclk_prev: 1'b0, flag: 1'b0};
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign sdo                 = s_ff.sdo;
  assign sdo_oe              = s_ff.sdo_oe;
  assign sample_ready_strobe = s_ff.strobe;

  // Checks.
  strobe_reset_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(sample_ready_strobe) |-> sdo == SDO_RESET && s_ff.cnt == CNT_RST)
    else $error("output not reset at strobe");
  early_reset_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    conv_valid && !cont_eff |=> sdo == SDO_RESET ##1 sample_ready_strobe)
    else $error("addressed output not reset one cycle early");
  msb_first_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_ff.armed && !cs_n_s && sclk_fall && s_ff.cnt == CNT_RST && !conv_valid
    && !s_ff.pend_v |=> sdo == s_ff.word[WORD_BITS-1] && s_ff.cnt == 6'h01)
    else $error("msb not first");
  hold_last_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_ff.cnt == WORD_LEN && !conv_valid && !s_ff.pend_v |=> $stable(sdo))
    else $error("last bit not held");
  pin_last_one_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    conv_valid && pin_mode |=> s_ff.pend[0] == 1'b1)
    else $error("pin mode last bit not one");
  pin_status_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    conv_valid && pin_mode |=> s_ff.pend[SUF_BITS-1:0] == $past(status_b))
    else $error("pin mode suffix not status");
  summary_or_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    status_b[ST_SUMMARY] == (status_b[ST_ERR_HI:ST_ERR_LO] != '0))
    else $error("summary bit wrong");
  pin_cont_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_ff.pend_v && !conv_valid && pin_mode |=> s_ff.armed)
    else $error("pin mode not continuous");
  ready_cont_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_ff.pend_v && !conv_valid && !cont_eff |=> !s_ff.armed)
    else $error("ready in addressed mode");
  word_pass_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    conv_valid |=> s_ff.pend[WORD_BITS-1:SUF_BITS] == $past(conv_data))
    else $error("result not in word");

  // The drive enable follows the synchronised select with one register of delay.
  oe_on_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !cs_n_s |=> sdo_oe)
    else $error("drive enable not raised");
  oe_off_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cs_n_s |=> !sdo_oe)
    else $error("drive enable not dropped");
  strobe_pulse_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    sample_ready_strobe |=> !sample_ready_strobe)
    else $error("strobe wider than one cycle");
  strobe_delay_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    conv_valid ##1 !conv_valid |=> sample_ready_strobe)
    else $error("strobe missing after conversion");
  count_cap_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_ff.cnt <= WORD_LEN)
    else $error("bit count beyond word");
  shift_step_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_ff.armed && !cs_n_s && sclk_fall && s_ff.cnt != WORD_LEN && !conv_valid
    && !s_ff.pend_v |=> s_ff.cnt == $past(s_ff.cnt) + 6'h01)
    else $error("shift did not advance count");
  word_load_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    s_ff.pend_v && !conv_valid |=> s_ff.word == $past(s_ff.pend))
    else $error("shift word not loaded");
  crc_suffix_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    conv_valid && crc_sel && !pin_mode
    |=> s_ff.pend[SUF_BITS-1:0] == crc8($past(conv_data)))
    else $error("crc suffix wrong");
  desel_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cs_n_s && !conv_valid && !s_ff.pend_v |=> s_ff.cnt == CNT_RST)
    else $error("count not cleared when deselected");
  unarmed_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !s_ff.armed && !conv_valid && !s_ff.pend_v |=> $stable(sdo))
    else $error("output moved while not armed");
  ready_flag_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    conv_valid && cont_eff |=> s_ff.flag)
    else $error("ready flag not set in continuous mode");
  addr_arm_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    read_req && !cont_eff && !conv_valid && !s_ff.pend_v && !cs_n_s |=> s_ff.armed)
    else $error("addressed read not armed");
  pin_por_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    conv_valid && pin_mode |=> s_ff.pend[ST_POR] == POR_PINMODE)
    else $error("pin mode power-on bit not one");

  full_read_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
    s_ff.cnt == WORD_LEN ##1 sample_ready_strobe);
  addressed_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
    read_req && !cont_eff ##[1:400] s_ff.cnt == WORD_LEN);
  crc_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
    conv_valid && crc_sel && !pin_mode);
  // A partial read cut short by deselect, and a full read under pin control.
  recover_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
    !cs_n_s && s_ff.cnt != CNT_RST && s_ff.cnt != WORD_LEN ##1 cs_n_s);
  pin_read_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
    pin_mode && s_ff.cnt == WORD_LEN);
endmodule

/* File: verif/crp_host.sv */
// Host controller model that clocks result words out of the readback port.
`timescale 1ns/1ps
module crp_host (
  // Master clock and serial pins
  input  wire logic sys_clk,
  input  wire logic sdo,
  output logic      sclk,
  output logic      cs_n
);
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
  end
  task automatic select(input logic lvl);
    @(negedge sys_clk);
    cs_n = lvl;
  endtask
  // Clocks a number of bits without capture, to lose alignment on purpose.
  task automatic clock_bits(input int n);
    for (int i = 0; i < n; i++) begin
      repeat (4) @(negedge sys_clk);
      sclk = 1'b0;
      repeat (4) @(negedge sys_clk);
      sclk = 1'b1;
    end
  endtask
  // The serial clock idles high and moves only on master clock falls.
  task automatic read_word(output logic [31:0] w);
    w = 32'h00000000;
    for (int i = 0; i < 32; i++) begin
      repeat (4) @(negedge sys_clk);
      sclk = 1'b0;
      repeat (4) @(negedge sys_clk);
      sclk = 1'b1;
      w = {w[30:0], sdo};
    end
  endtask
endmodule

/* File: verif/tb.sv */
// Self-checking bench for the conversion readback port.
`timescale 1ns/1ps
module tb;
  import crp_pkg::*;
  logic                sys_clk, rst_n, conv_valid, por_flag, read_req;
  logic                pin_mode, cont_mode, crc_sel, sclk, cs_n, sdo, sdo_oe, strobe;
  logic [RES_BITS-1:0] conv_data;
  logic [ERR_W-1:0]    err_flags;
  int                  err_count, cmp_count, cycles;
  crp_readback i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .conv_valid(conv_valid),
    .conv_data(conv_data), .err_flags(err_flags), .por_flag(por_flag),
    .pin_mode(pin_mode), .cont_mode(cont_mode), .crc_sel(crc_sel), .read_req(read_req),
    .sclk(sclk), .cs_n(cs_n), .sdo(sdo), .sdo_oe(sdo_oe), .sample_ready_strobe(strobe));
  crp_host i_host (.sys_clk(sys_clk), .sdo(sdo), .sclk(sclk), .cs_n(cs_n));
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_of_test();
    $display("Compared %0d, mismatched %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  function automatic logic [7:0] crc8(input logic [23:0] d);
    logic [7:0] c;
    c = CRC_INIT;
    for (int i = 23; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? CRC_POLY : 8'h00);
    return c;
  endfunction
  // Starts a conversion and checks the strobe and the output reset around it.
  task automatic convert(input logic [23:0] d, input logic [5:0] e, input logic early);
    conv_data = d;
    err_flags = e;
    conv_valid = 1'b1;
    @(posedge sys_clk) #1;
    conv_valid = 1'b0;
    if (early) chk("early sdo", 32'h0, {31'h0, sdo});
    @(posedge sys_clk) #1;
    chk("strobe", 32'h1, {31'h0, strobe});
    chk("sdo at strobe", 32'h0, {31'h0, sdo});
    @(posedge sys_clk) #1;
    chk("strobe width", 32'h0, {31'h0, strobe});
  endtask
  task automatic rd(input string what, input logic [31:0] exp);
    logic [31:0] w;
    i_host.read_word(w);
    chk(what, exp, w);
    repeat (16) @(posedge sys_clk);
    #1 chk("held bit", {31'h0, exp[0]}, {31'h0, sdo});
    $display("Test %s done", what);
  endtask
  task automatic t_pin();
    pin_mode = 1'b1;
    crc_sel = 1'b1;
    chk("drive enable", 32'h1, {31'h0, sdo_oe});
    convert(24'hA5C3F1, 6'h00, 1'b0);
    rd("pin word", {24'hA5C3F1, 8'h01});
    convert(24'h5A3C0E, 6'h24, 1'b0);
    rd("pin error word", {24'h5A3C0E, 8'hC9});
    pin_mode = 1'b0;
  endtask
  task automatic t_crc();
    cont_mode = 1'b1;
    convert(24'h800001, 6'h3F, 1'b0);
    rd("crc word", {24'h800001, crc8(24'h800001)});
  endtask
  task automatic t_status();
    crc_sel = 1'b0;
    convert(24'h123456, 6'h01, 1'b0);
    rd("status word", {24'h123456, 8'h83});
  endtask
  task automatic t_recover();
    convert(24'h3C3C3C, 6'h00, 1'b0);
    i_host.clock_bits(5);
    i_host.select(1'b1);
    repeat (4) @(posedge sys_clk);
    #1 chk("drive enable off", 32'h0, {31'h0, sdo_oe});
    i_host.select(1'b0);
    repeat (4) @(posedge sys_clk);
    #1 rd("recovered word", {24'h3C3C3C, 8'h01});
  endtask
  task automatic t_addr();
    cont_mode = 1'b0;
    convert(24'h0F0F0F, 6'h00, 1'b1);
    read_req = 1'b1;
    @(posedge sys_clk) #1;
    read_req = 1'b0;
    rd("addressed word", {24'h0F0F0F, 8'h01});
  endtask
  task automatic t_unarmed();
    convert(24'hFFFFFF, 6'h3F, 1'b1);
    rd("unaddressed word", 32'h00000000);
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 6000) begin
      err_count++;
      end_of_test();
    end
  end
  initial begin
    {rst_n, conv_valid, read_req, pin_mode, cont_mode, crc_sel} = 6'h00;
    por_flag = 1'b1;
    conv_data = 24'h000000;
    err_flags = 6'h00;
    repeat (8) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    i_host.select(1'b0);
    repeat (6) @(posedge sys_clk);
    #1;
    t_pin();
    t_crc();
    t_status();
    t_recover();
    t_addr();
    t_unarmed();
    end_of_test();
  end
endmodule
